// ===== hdl/dcsw_pkg.sv
// Purpose: shared constants for the drive command/status word block
// Assumes: 16-bit command, status, reference and frequency words
// Notes: bit 0 is the least significant bit of every word
package dcsw_pkg;
	// profile selection value that enables this command layout
	localparam logic [7:0] DCSW_PROFILE_BUS = 8'h00;
	// command word bit positions
	localparam int CMD_OFF1 = 0;
	localparam int CMD_OFF2 = 1;
	localparam int CMD_OFF3 = 2;
	localparam int CMD_COAST = 3;
	localparam int CMD_JOG1 = 8;
	localparam int CMD_JOG2 = 9;
	localparam int CMD_VALID = 10;
	localparam int CMD_SLOW = 11;
	localparam int CMD_CATCH = 12;
	localparam int CMD_SETUP_LSB = 13;
	localparam int CMD_SETUP_MSB = 14;
	localparam int CMD_REV = 15;
	// status word bit positions
	localparam int ST_CTRL_RDY = 0;
	localparam int ST_DRV_RDY = 1;
	localparam int ST_NO_COAST = 2;
	localparam int ST_TRIP = 3;
	localparam int ST_OFF2 = 4;
	localparam int ST_OFF3 = 5;
	localparam int ST_INHIBIT = 6;
	localparam int ST_WARN = 7;
	localparam int ST_AT_REF = 8;
	localparam int ST_REMOTE = 9;
	localparam int ST_IN_LIMIT = 10;
	localparam int ST_RUNNING = 11;
	localparam int ST_VOLT = 13;
	localparam int ST_CURR = 14;
	localparam int ST_THERM = 15;
	// values after reset: all stops active, start inhibit set
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [15:0] REF_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0070;
	localparam logic [15:0] FREQ_RESET = 16'h0000;
	// reference scaling: 4000 hex is 100 percent, 7FFF hex is the limit
	localparam int REF_SHIFT = 14;
	localparam logic [31:0] REF_FULL = 32'h0000_4000;
	localparam logic signed [17:0] REF_POS_MAX = 18'sh07FFF;
	localparam logic signed [17:0] REF_NEG_MAX = -18'sh07FFF;
	localparam logic [31:0] FREQ_WORD_MAX = 32'h0000_7FFF;
	// sources allowed to command reversal
	localparam logic [1:0] REVSRC_DIGITAL = 2'h0;
	localparam logic [1:0] REVSRC_SERIAL = 2'h1;
	localparam logic [1:0] REVSRC_AND = 2'h2;
	localparam logic [1:0] REVSRC_OR = 2'h3;
	typedef logic [15:0] dcsw_word_t;
endpackage : dcsw_pkg

// ===== hdl/dcsw_ref_scale.sv
// Purpose: map a signed reference word onto a low..high span
// Assumes: hi is not below lo; magnitude 16384 gives the full span
// Notes: result saturates at the top of the 16-bit range
`timescale 1ns/100ps
`default_nettype none
module dcsw_ref_scale #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] ref_word,
	input wire logic [W-1:0] span_lo,
	input wire logic [W-1:0] span_hi,
	output logic [W-1:0] freq,
	output logic neg
);
	import dcsw_pkg::*;
	logic [W:0] mag;
	logic [W-1:0] span;
	logic [2*W:0] prod;
	logic [2*W:0] sum;

	// two's complement magnitude, scaled the same both ways
	always_comb begin
		mag = ref_word[W-1] ? ((W+1)'(0) - {1'b1, ref_word}) : {1'b0, ref_word};
		span = (span_hi > span_lo) ? (span_hi - span_lo) : '0;
		prod = (2*W+1)'(span) * (2*W+1)'(mag);
		sum = (2*W+1)'(span_lo) + (prod >> REF_SHIFT);
	end

	// registered result, saturated rather than wrapped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freq <= '0;
			neg <= 1'b0;
		end else begin
			freq <= (sum[2*W:W] != '0) ? '1 : sum[W-1:0];
			neg <= ref_word[W-1];
		end
	end
endmodule : dcsw_ref_scale
`default_nettype wire

// ===== hdl/dcsw_core.sv
// Purpose: decode the bus command word, build the status word, scale reference/frequency
// Assumes: command and reference arrive together on one write strobe
// Notes: drive state (ready, trip, frequency, warnings) comes from the motor control
// Functional notes
// - only act on command words while profile selection equals zero
// - any of command bits 0..2 low requests a ramp stop
// - bits 0..2 all high permit start if other start conditions hold
// - optional relay energised at zero output frequency during ramp stop
// - command bit 8 selects first bus jog frequency
// - command bit 9 selects second bus jog frequency
// - command bit 11 lowers reference by the adjustment amount
// - command bit 12 raises reference by the adjustment amount
// - with bits 11 and 12 both high, only the decrease applies
// - status bit 0 high only when bits 0..2 high and drive ready
// - status bit 2 high only when bits 0..3 high and not tripped
// - status bit 4 is inverse of command bit 1
// - status bit 5 is inverse of command bit 2
// - start inhibit set after trip reset, stop activation, power-up
// - inhibit clears on bit 0 low with bits 1, 2, 10 high
// - reference is signed 16-bit, magnitude up to 32767
// - reference 0..16384 maps linearly onto minimum..maximum reference
// - negative reference reverses rotation, same magnitude scaling
// - output frequency reported signed, 16384 equals low..high limit span
// - command word ignored while bit 10 is zero
// - bits 14:13 select setup when multi-setup is configured
// - bit 15 requests reversal when the reversing source allows serial
// - status bit 3 set on trip, held until reset
`timescale 1ns/100ps
`default_nettype none
module dcsw_core #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire dcsw_pkg::dcsw_word_t cmd_in,
	input wire dcsw_pkg::dcsw_word_t ref_in,
	input wire logic [7:0] profile_sel,
	input wire logic multi_setup_en,
	input wire logic [1:0] rev_source,
	input wire logic rev_input,
	input wire logic relay_zero_en,
	input wire dcsw_pkg::dcsw_word_t adjust_amount,
	input wire dcsw_pkg::dcsw_word_t jog1_freq,
	input wire dcsw_pkg::dcsw_word_t jog2_freq,
	input wire dcsw_pkg::dcsw_word_t ref_min,
	input wire dcsw_pkg::dcsw_word_t ref_max,
	input wire dcsw_pkg::dcsw_word_t freq_low,
	input wire dcsw_pkg::dcsw_word_t freq_high,
	input wire dcsw_pkg::dcsw_word_t out_freq,
	input wire logic out_rev,
	input wire logic drive_ready,
	input wire logic start_ok,
	input wire logic trip_event,
	input wire logic trip_reset,
	input wire logic warn,
	input wire logic remote_ok,
	input wire logic volt_warn,
	input wire logic curr_limit,
	input wire logic therm_warn,
	output dcsw_pkg::dcsw_word_t drive_state_word,
	output dcsw_pkg::dcsw_word_t freq_word,
	output dcsw_pkg::dcsw_word_t freq_target,
	output logic reverse,
	output logic ramp_stop,
	output logic start_permit,
	output logic relay_on,
	output logic [1:0] setup_sel
);
	import dcsw_pkg::*;

	// ********************************
	// command capture
	// ********************************
	dcsw_word_t command_word;
	dcsw_word_t ref_word;
	logic prof_ok;
	assign prof_ok = (profile_sel == DCSW_PROFILE_BUS);

	// both words taken on one strobe; the reference is taken even when bit 10 is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			command_word <= CMD_RESET;
			ref_word <= REF_RESET;
		end else if (cmd_wr && prof_ok) begin
			ref_word <= ref_in;
			if (cmd_in[CMD_VALID]) begin
				command_word <= cmd_in;
			end
		end
	end

	// ********************************
	// trip and start inhibit latches
	// ********************************
	logic tripped;
	logic inhibit;
	logic [1:0] stops_prev;
	logic stop_edge;
	logic inhibit_clr;

	// an off2 or off3 stop counts as activated on the edge into the stopped level
	assign stop_edge = (stops_prev[0] & ~command_word[CMD_OFF2])
		| (stops_prev[1] & ~command_word[CMD_OFF3]);
	assign inhibit_clr = ~command_word[CMD_OFF1] & command_word[CMD_OFF2]
		& command_word[CMD_OFF3] & command_word[CMD_VALID];

	// trip flag: new trip beats a reset in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tripped <= 1'b0;
		end else if (trip_event) begin
			tripped <= 1'b1;
		end else if (trip_reset) begin
			tripped <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stops_prev <= 2'b00;
		end else begin
			stops_prev <= {command_word[CMD_OFF3], command_word[CMD_OFF2]};
		end
	end

	// inhibit: set sources win over the clear pattern
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			inhibit <= 1'b1;
		end else if ((tripped && trip_reset && !trip_event) || stop_edge) begin
			inhibit <= 1'b1;
		end else if (inhibit_clr) begin
			inhibit <= 1'b0;
		end
	end

	// ********************************
	// reference adjustment
	// ********************************
	logic signed [17:0] ref_ext;
	logic signed [17:0] adj_ext;
	logic signed [17:0] next_adj;
	dcsw_word_t adj_ref;

	always_comb begin
		ref_ext = 18'(signed'(ref_word));
		adj_ext = signed'({2'b00, adjust_amount});
		if (command_word[CMD_SLOW]) begin
			next_adj = ref_ext - adj_ext;
		end else if (command_word[CMD_CATCH]) begin
			next_adj = ref_ext + adj_ext;
		end else begin
			next_adj = ref_ext;
		end
		// keep magnitude within 32767
		if (next_adj > REF_POS_MAX) begin
			next_adj = REF_POS_MAX;
		end else if (next_adj < REF_NEG_MAX) begin
			next_adj = REF_NEG_MAX;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			adj_ref <= REF_RESET;
		end else begin
			adj_ref <= next_adj[15:0];
		end
	end

	// ********************************
	// reference to frequency, target select
	// ********************************
	dcsw_word_t ref_freq;
	logic ref_neg;
	logic rev_req;

	// span scaling with sign split off
	dcsw_ref_scale #(
		.W(W)
	) u_scale (
		.clk(clk),
		.rst(rst),
		.ref_word(adj_ref),
		.span_lo(ref_min),
		.span_hi(ref_max),
		.freq(ref_freq),
		.neg(ref_neg)
	);

	// reversal source gating of command bit 15
	always_comb begin
		case (rev_source)
			REVSRC_SERIAL: rev_req = command_word[CMD_REV];
			REVSRC_AND: rev_req = command_word[CMD_REV] & rev_input;
			REVSRC_OR: rev_req = command_word[CMD_REV] | rev_input;
			default: rev_req = rev_input;
		endcase
	end

	// jog 1 ahead of jog 2 ahead of the scaled reference
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freq_target <= FREQ_RESET;
			reverse <= 1'b0;
		end else begin
			if (command_word[CMD_JOG1]) begin
				freq_target <= jog1_freq;
			end else if (command_word[CMD_JOG2]) begin
				freq_target <= jog2_freq;
			end else begin
				freq_target <= ref_freq;
			end
			reverse <= ref_neg ^ rev_req;
		end
	end

	// ********************************
	// run control outputs
	// ********************************
	logic all_on;
	assign all_on = &command_word[CMD_OFF3:CMD_OFF1];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ramp_stop <= 1'b1;
			start_permit <= 1'b0;
			relay_on <= 1'b0;
			setup_sel <= 2'b00;
		end else begin
			ramp_stop <= ~all_on;
			start_permit <= all_on & start_ok & ~inhibit & ~tripped;
			relay_on <= relay_zero_en & ~all_on & (out_freq == '0);
			if (multi_setup_en) begin
				setup_sel <= command_word[CMD_SETUP_MSB:CMD_SETUP_LSB];
			end
		end
	end

	// ********************************
	// status word, rebuilt every clock
	// ********************************
	dcsw_word_t next_status;
	always_comb begin
		next_status = '0;
		next_status[ST_CTRL_RDY] = all_on & drive_ready;
		next_status[ST_DRV_RDY] = drive_ready;
		next_status[ST_NO_COAST] = all_on & command_word[CMD_COAST] & ~tripped;
		next_status[ST_TRIP] = tripped;
		next_status[ST_OFF2] = ~command_word[CMD_OFF2];
		next_status[ST_OFF3] = ~command_word[CMD_OFF3];
		next_status[ST_INHIBIT] = inhibit;
		next_status[ST_WARN] = warn;
		next_status[ST_AT_REF] = (out_freq == freq_target);
		next_status[ST_REMOTE] = remote_ok;
		next_status[ST_IN_LIMIT] = (out_freq > freq_low) && (out_freq < freq_high);
		next_status[ST_RUNNING] = start_permit | (out_freq != '0);
		next_status[ST_VOLT] = volt_warn;
		next_status[ST_CURR] = curr_limit;
		next_status[ST_THERM] = therm_warn;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			drive_state_word <= STATUS_RESET;
		end else begin
			drive_state_word <= next_status;
		end
	end

	// ********************************
	// present frequency report
	// ********************************
	logic [31:0] f_num;
	logic [31:0] f_span;
	logic [31:0] f_quot;
	logic [15:0] f_mag;

	// a zero span reports zero rather than dividing by zero
	always_comb begin
		f_span = (freq_high > freq_low) ? 32'(freq_high - freq_low) : 32'h0;
		f_num = (out_freq > freq_low) ? (32'(out_freq - freq_low) << REF_SHIFT) : 32'h0;
		f_quot = (f_span == 32'h0) ? 32'h0 : (f_num / f_span);
		f_mag = (f_quot > FREQ_WORD_MAX) ? FREQ_WORD_MAX[15:0] : f_quot[15:0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			freq_word <= FREQ_RESET;
		end else begin
			freq_word <= out_rev ? (16'h0000 - f_mag) : f_mag;
		end
	end

	// ********************************
	// checks
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_stop_on;
		command_word[CMD_OFF2] && command_word[CMD_OFF3];
	endsequence
	sequence s_stop_off;
		!command_word[CMD_OFF2];
	endsequence
	sequence s_clear_pattern;
		inhibit_clr && !trip_reset && !trip_event;
	endsequence

	AST_PROFILE_GATE: assert property (
		cmd_wr && !prof_ok |=> $stable(command_word) && $stable(ref_word))
		else $error("word taken under another profile");
	AST_VALID_GATE: assert property (
		cmd_wr && !cmd_in[CMD_VALID] |=> $stable(command_word))
		else $error("command taken with data-valid low");
	AST_RAMP_STOP: assert property (
		!all_on |=> ramp_stop)
		else $error("ramp stop not asserted");
	AST_START: assert property (
		start_permit |-> $past(all_on) && !$past(inhibit))
		else $error("start permitted without all on");
	AST_RELAY: assert property (
		relay_zero_en && !all_on && out_freq == '0 |=> relay_on)
		else $error("zero-frequency relay not energised");
	AST_JOG1: assert property (
		command_word[CMD_JOG1] |=> freq_target == $past(jog1_freq))
		else $error("jog 1 frequency not selected");
	AST_JOG2: assert property (
		!command_word[CMD_JOG1] && command_word[CMD_JOG2]
		|=> freq_target == $past(jog2_freq))
		else $error("jog 2 frequency not selected");
	AST_SLOW_WINS: assert property (
		command_word[CMD_SLOW] && adjust_amount != '0 && $signed(ref_word) > 0
		|=> $signed(adj_ref) < $signed($past(ref_word)))
		else $error("slow-down did not lower reference");
	AST_ST_BIT0: assert property (
		!(all_on && drive_ready) |=> !drive_state_word[ST_CTRL_RDY])
		else $error("control ready with stop active");
	AST_ST_BIT2: assert property (
		tripped || !command_word[CMD_COAST] |=> !drive_state_word[ST_NO_COAST])
		else $error("coast bit high while tripped or coasting");
	AST_ST_MIRROR: assert property (
		##1 drive_state_word[ST_OFF2] == !$past(command_word[CMD_OFF2])
		&& drive_state_word[ST_OFF3] == !$past(command_word[CMD_OFF3]))
		else $error("stop mirror bits wrong");
	AST_INHIBIT_SET: assert property (
		s_stop_on ##1 s_stop_off |=> inhibit ##1 drive_state_word[ST_INHIBIT])
		else $error("inhibit not set after stop");
	AST_INHIBIT_CLR: assert property (
		s_clear_pattern and !stop_edge |=> !inhibit)
		else $error("inhibit not cleared");
	AST_REF_RANGE: assert property (
		$signed(adj_ref) >= -32767)
		else $error("reference beyond limit");
	AST_TRIP_HOLD: assert property (
		tripped && !trip_reset |=> tripped)
		else $error("trip flag dropped without reset");
	AST_FREQ_SIGN: assert property (
		out_rev && out_freq > freq_low && freq_high > out_freq |=> freq_word[15])
		else $error("reverse frequency not negative");
endmodule : dcsw_core
`default_nettype wire

// ===== dv/dcsw_master.sv
// Purpose: bus master model presenting command and reference words
// Assumes: one go pulse per write, sampled on the rising clock edge
// Notes: released data lines show the inverse of the last word
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// master write driver
// ****************************************
module dcsw_master (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire dcsw_pkg::dcsw_word_t cmd,
	input wire dcsw_pkg::dcsw_word_t refw,
	output logic cmd_wr,
	output dcsw_pkg::dcsw_word_t cmd_in,
	output dcsw_pkg::dcsw_word_t ref_in
);
	import dcsw_pkg::*;
	// both words go out on one strobe; stale lines are scrambled so no reuse hides
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_wr <= 1'b0;
			cmd_in <= 16'h0000;
			ref_in <= 16'h0000;
		end else if (go) begin
			cmd_wr <= 1'b1;
			cmd_in <= cmd;
			ref_in <= refw;
		end else if (cmd_wr) begin
			cmd_wr <= 1'b0;
			cmd_in <= ~cmd_in;
			ref_in <= ~ref_in;
		end
	end
endmodule : dcsw_master
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: self-checking bench for the command/status word block
// Assumes: settled outputs are read a few cycles after each write
// Notes: reference span chosen so the scaling is exact
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin failures++; \
	$display("ERROR %s expected %h seen %h", nm, ex, gt); end end
// ****************************************
// bench top
// ****************************************
module testbench;
	import dcsw_pkg::*;
	logic clk = 1'b0, rst = 1'b1, go = 1'b0;
	dcsw_word_t cmd_v = 16'h0000, ref_v = 16'h0000, cmd_in, ref_in;
	logic cmd_wr;
	logic [7:0] profile_sel = 8'h00;
	logic multi_setup_en = 1'b0, rev_input = 1'b0, relay_zero_en = 1'b0, out_rev = 1'b0;
	logic [1:0] rev_source = REVSRC_DIGITAL;
	dcsw_word_t adjust_amount = 16'h1000, jog1_freq = 16'h0123, jog2_freq = 16'h0456;
	dcsw_word_t ref_min = 16'h0100, ref_max = 16'h4100;
	dcsw_word_t freq_low = 16'h0000, freq_high = 16'h0032, out_freq = 16'h0000;
	logic drive_ready = 1'b1, start_ok = 1'b0, trip_event = 1'b0, trip_reset = 1'b0;
	logic warn = 1'b0, remote_ok = 1'b0, volt_warn = 1'b0, curr_limit = 1'b0, therm_warn = 1'b0;
	dcsw_word_t drive_state_word, freq_word, freq_target;
	logic reverse, ramp_stop, start_permit, relay_on;
	logic [1:0] setup_sel;
	int failures = 0, tests_run = 0;
	// 20 MHz clock
	always #25 clk = ~clk;
	dcsw_master i_dcsw_master (.clk(clk), .rst(rst), .go(go), .cmd(cmd_v), .refw(ref_v),
		.cmd_wr(cmd_wr), .cmd_in(cmd_in), .ref_in(ref_in));
	dcsw_core i_dcsw_core (.clk(clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_in(cmd_in),
		.ref_in(ref_in), .profile_sel(profile_sel), .multi_setup_en(multi_setup_en),
		.rev_source(rev_source), .rev_input(rev_input), .relay_zero_en(relay_zero_en),
		.adjust_amount(adjust_amount), .jog1_freq(jog1_freq), .jog2_freq(jog2_freq),
		.ref_min(ref_min), .ref_max(ref_max), .freq_low(freq_low), .freq_high(freq_high),
		.out_freq(out_freq), .out_rev(out_rev), .drive_ready(drive_ready),
		.start_ok(start_ok), .trip_event(trip_event), .trip_reset(trip_reset),
		.warn(warn), .remote_ok(remote_ok), .volt_warn(volt_warn),
		.curr_limit(curr_limit), .therm_warn(therm_warn),
		.drive_state_word(drive_state_word), .freq_word(freq_word),
		.freq_target(freq_target), .reverse(reverse), .ramp_stop(ramp_stop),
		.start_permit(start_permit), .relay_on(relay_on), .setup_sel(setup_sel));
	// expected target: linear map of a magnitude onto the reference span
	function automatic dcsw_word_t scale(input logic [15:0] mag);
		logic [31:0] p;
		p = 32'(ref_max - ref_min) * 32'(mag);
		return ref_min + 16'(p >> 14);
	endfunction : scale
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	// one paired write, then long enough for the slowest path to land
	task automatic wr(input dcsw_word_t c, input dcsw_word_t r);
		cmd_v <= c;
		ref_v <= r;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : wr
	task automatic t_start();
		wr(16'h047F, 16'h2000);
		`CHK("status start", 16'h0047, drive_state_word)
		`CHK("ramp stop", 1'b0, ramp_stop)
		`CHK("target", scale(16'h2000), freq_target)
		wr(16'h0406, 16'h2000);
		`CHK("status clear", 16'h0002, drive_state_word)
		start_ok <= 1'b1;
		wr(16'h047F, 16'h2000);
		`CHK("permit", 1'b1, start_permit)
		`CHK("status run", 16'h0807, drive_state_word)
		wr(16'h047D, 16'h2000);
		`CHK("status off2", 16'h0052, drive_state_word)
		`CHK("ramp stop off2", 1'b1, ramp_stop)
		wr(16'h047B, 16'h2000);
		`CHK("status off3", 16'h0062, drive_state_word)
		$display("test start done");
	endtask : t_start
	task automatic t_ignore();
		wr(16'h007F, 16'h2000);
		`CHK("invalid word", 16'h0062, drive_state_word)
		profile_sel <= 8'h01;
		wr(16'h047F, 16'h3000);
		`CHK("profile status", 16'h0062, drive_state_word)
		`CHK("profile ref", scale(16'h2000), freq_target)
		profile_sel <= 8'h00;
		$display("test ignore done");
	endtask : t_ignore
	task automatic t_jog_adjust();
		wr(16'h057F, 16'h2000);
		`CHK("jog1", jog1_freq, freq_target)
		wr(16'h067F, 16'h2000);
		`CHK("jog2", jog2_freq, freq_target)
		wr(16'h147F, 16'h2000);
		`CHK("catch up", scale(16'h3000), freq_target)
		wr(16'h0C7F, 16'h2000);
		`CHK("slow down", scale(16'h1000), freq_target)
		wr(16'h1C7F, 16'h2000);
		`CHK("both", scale(16'h1000), freq_target)
		$display("test jog_adjust done");
	endtask : t_jog_adjust
	task automatic t_reverse();
		wr(16'h847F, 16'hE000);
		`CHK("neg ref", 1'b1, reverse)
		`CHK("neg target", scale(16'h2000), freq_target)
		rev_source <= REVSRC_SERIAL;
		wr(16'h847F, 16'h2000);
		`CHK("bit15 rev", 1'b1, reverse)
		wr(16'h847F, 16'hE000);
		`CHK("bit15 xor", 1'b0, reverse)
		out_freq <= 16'h0019;
		repeat (3) @(posedge clk);
		`CHK("freq fwd", 16'h2000, freq_word)
		out_rev <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("freq rev", 16'hE000, freq_word)
		out_rev <= 1'b0;
		out_freq <= 16'h0000;
		$display("test reverse done");
	endtask : t_reverse
	task automatic t_trip();
		wr(16'h0406, 16'h2000);
		wr(16'h047F, 16'h2000);
		trip_event <= 1'b1;
		@(posedge clk);
		trip_event <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK("trip bit", 1'b1, drive_state_word[ST_TRIP])
		`CHK("trip coast", 1'b0, drive_state_word[ST_NO_COAST])
		`CHK("trip inhibit", 1'b0, drive_state_word[ST_INHIBIT])
		trip_reset <= 1'b1;
		@(posedge clk);
		trip_reset <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK("trip cleared", 1'b0, drive_state_word[ST_TRIP])
		`CHK("reset inhibit", 1'b1, drive_state_word[ST_INHIBIT])
		$display("test trip done");
	endtask : t_trip
	task automatic t_setup_relay();
		multi_setup_en <= 1'b1;
		wr(16'h447F, 16'h2000);
		`CHK("setup", 2'h2, setup_sel)
		multi_setup_en <= 1'b0;
		wr(16'h247F, 16'h2000);
		`CHK("setup held", 2'h2, setup_sel)
		relay_zero_en <= 1'b1;
		wr(16'h047E, 16'h2000);
		`CHK("relay stop", 1'b1, relay_on)
		wr(16'h047F, 16'h2000);
		`CHK("relay run", 1'b0, relay_on)
		$display("test setup_relay done");
	endtask : t_setup_relay
	// drive-state inputs, the other reversing sources, then a reset in mid-run
	task automatic t_flags();
		warn <= 1'b1;
		remote_ok <= 1'b1;
		volt_warn <= 1'b1;
		curr_limit <= 1'b1;
		therm_warn <= 1'b1;
		drive_ready <= 1'b0;
		out_freq <= 16'h0019;
		repeat (3) @(posedge clk);
		`CHK("status flags", 16'hEE84, drive_state_word)
		rev_source <= REVSRC_AND;
		rev_input <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("rev and", 1'b0, reverse)
		rev_source <= REVSRC_OR;
		repeat (3) @(posedge clk);
		`CHK("rev or", 1'b1, reverse)
		// power-up again: inhibit must come back and ramp stop must read active
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK("rerun inhibit", 1'b1, drive_state_word[ST_INHIBIT])
		`CHK("rerun ramp stop", 1'b1, ramp_stop)
		$display("test flags done");
	endtask : t_flags
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		close_out();
	end
	initial begin
		repeat (8) @(posedge clk);
		`CHK("reset status", STATUS_RESET, drive_state_word)
		rst <= 1'b0;
		@(posedge clk);
		t_start();
		t_ignore();
		t_jog_adjust();
		t_reverse();
		t_trip();
		t_setup_relay();
		t_flags();
		close_out();
	end
endmodule : testbench
`default_nettype wire
